//--- shared/param_table_pkg.sv
// ----------------------------------------------------------------
// Shared constants for the parameter-table link
// ----------------------------------------------------------------
package param_table_pkg;

    // Link widths
    localparam int OPCODE_W = 8;
    localparam int ADDR_W = 24;
    localparam int MODE_W = 3;
    localparam int DUMMY_W = 5;

    // Opcodes used by both ends
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET_MEMORY = 8'h99;
    localparam logic [7:0] OP_QUAD_ENABLE = 8'h38;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
    localparam logic [7:0] OP_READ_PROTECT = 8'h72;
    localparam logic [7:0] OP_WRITE_PROTECT = 8'h42;
    localparam logic [7:0] OP_LOCK_PROTECT = 8'h8D;
    localparam logic [7:0] OP_NV_LOCK_DOWN = 8'hE8;
    localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
    localparam logic [7:0] OP_READ_SEC_ID = 8'h88;
    localparam logic [7:0] OP_PROGRAM_SEC_ID = 8'hA5;
    localparam logic [7:0] OP_LOCKOUT_SEC_ID = 8'h85;
    localparam logic [7:0] OP_BURST_LENGTH = 8'hC0;
    localparam logic [7:0] OP_PARAM_READ = 8'h5A;
    localparam logic [7:0] OP_WRAP_READ_144 = 8'hEC;

    // Wrapped 1-4-4 read: dummy clocks and mode bits
    localparam logic [4:0] WRAP_DUMMY_CLOCKS = 5'h06;
    localparam logic [2:0] WRAP_MODE_BITS = 3'h0;

    // Table window and filler value
    localparam logic [23:0] TABLE_BASE = 24'h00021A;
    localparam int TABLE_LEN = 36;
    localparam logic [7:0] FILLER = 8'hFF;
    localparam logic [7:0] NO_DATA = 8'hFF;

    // Fixed table content, index 0 is byte 21AH
    localparam logic [7:0] TABLE_ROM [0:TABLE_LEN-1] = '{
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h00, 8'h66, 8'h99, 8'h38, 8'hFF, 8'h05, 8'h01, 8'h35,
        8'h06, 8'h04, 8'h02, 8'h32, 8'hB0, 8'h30, 8'h72, 8'h42,
        8'h8D, 8'hE8, 8'h98, 8'h88, 8'hA5, 8'h85, 8'hC0, 8'h9F,
        8'hAF, 8'h5A, 8'hFF, 8'hFF,
        {WRAP_MODE_BITS, WRAP_DUMMY_CLOCKS}, OP_WRAP_READ_144
    };

    // Host request kinds
    typedef enum logic [3:0] {
        KIND_PARAM_READ = 4'h0,
        KIND_PAGE_PROGRAM = 4'h1,
        KIND_QUAD_PAGE_PROGRAM = 4'h2,
        KIND_READ_PROTECT = 4'h3,
        KIND_WRITE_PROTECT = 4'h4,
        KIND_LOCK_PROTECT = 4'h5,
        KIND_NV_LOCK_DOWN = 4'h6,
        KIND_GLOBAL_UNLOCK = 4'h7,
        KIND_READ_SEC_ID = 4'h8,
        KIND_PROGRAM_SEC_ID = 4'h9,
        KIND_LOCKOUT_SEC_ID = 4'hA,
        KIND_WRAP_READ = 4'hB
    } req_kind_t;

endpackage

//--- shared/param_link_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Link between host controller and table device
// ----------------------------------------------------------------
interface param_link_if;
    import param_table_pkg::*;

    logic req; // One-cycle request strobe
    logic [OPCODE_W-1:0] opcode; // Command opcode
    logic [ADDR_W-1:0] addr; // Byte address
    logic [MODE_W-1:0] mode_bits; // Mode bits sent by host
    logic ack; // One-cycle answer strobe
    logic [7:0] data; // Answer byte
    logic accepted; // Opcode was taken

    modport device (input req, input opcode, input addr, input mode_bits,
                    output ack, output data, output accepted);
    modport host (output req, output opcode, output addr, output mode_bits,
                  input ack, input data, input accepted);
endinterface

//--- rtl/param_table_device.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Reserved bytes 21BH..21FH read as FFH
// RULE2 - Byte 21AH reports reserved power-down exit time
// RULE3 - Advertise and accept block-protection opcodes
// RULE4 - Advertise security-identifier opcodes 88H A5H 85H
// RULE5 - Program opcodes 02H and 32H advertised, used
// RULE6 - Deep power-down opcodes read as FFH
// RULE7 - Wrapped 1-4-4 read needs six dummy clocks
// RULE8 - Wrapped read advertises zero mode bits
// RULE9 - Byte 23DH holds wrapped read opcode ECH
// RULE10 - Table content fixed, read-only, unaffected by writes
// RULE11 - Basic control opcodes advertised at 220H..23BH
module param_table_device
    import param_table_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Link to host
    param_link_if.device link,
    // Accepted command toward execution logic
    output logic o_cmd_valid,
    output logic [OPCODE_W-1:0] o_cmd_opcode,
    output logic [ADDR_W-1:0] o_cmd_addr
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Index width of the fixed table
    localparam int IDX_W = $clog2(TABLE_LEN);

    // Table lookup, filler outside the window
    function automatic logic [7:0] table_byte(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] idx;
        // Below the window the subtraction wraps, so both bounds are tested
        idx = a - TABLE_BASE;
        if (a >= TABLE_BASE && idx < ADDR_W'(TABLE_LEN)) begin
            table_byte = TABLE_ROM[idx[IDX_W-1:0]]; // RULE1 RULE2 RULE6 RULE8 RULE9 RULE10 RULE11
        end else begin
            table_byte = FILLER;
        end
    endfunction

    // Opcodes the device takes
    function automatic logic opcode_known(input logic [OPCODE_W-1:0] op);
        case (op)
            OP_NOP, OP_RESET_ENABLE, OP_RESET_MEMORY, OP_QUAD_ENABLE,
            OP_WRITE_ENABLE, OP_BURST_LENGTH, OP_PARAM_READ: opcode_known = 1'b1; // RULE11
            OP_READ_PROTECT, OP_WRITE_PROTECT, OP_LOCK_PROTECT,
            OP_NV_LOCK_DOWN, OP_GLOBAL_UNLOCK: opcode_known = 1'b1; // RULE3
            OP_READ_SEC_ID, OP_PROGRAM_SEC_ID, OP_LOCKOUT_SEC_ID: opcode_known = 1'b1; // RULE4
            OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM: opcode_known = 1'b1; // RULE5
            OP_WRAP_READ_144: opcode_known = 1'b1; // RULE9
            default: opcode_known = 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DUMMY = 3'b010,
        ST_REPLY = 3'b100
    } dev_state_t;

    dev_state_t state_reg; // Sequencer state
    logic [DUMMY_W-1:0] dummy_reg; // Dummy clocks left
    logic [OPCODE_W-1:0] op_reg; // Latched opcode
    logic [ADDR_W-1:0] addr_reg; // Latched address
    logic [MODE_W-1:0] mode_reg; // Latched mode bits
    logic ack_reg; // Answer strobe
    logic [7:0] data_reg; // Answer byte
    logic acc_reg; // Accepted flag
    logic cmd_valid_reg; // Command strobe out
    logic accept_now; // Current request is valid
    logic take_req; // Request seen while idle
    logic last_dummy; // Final dummy clock

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------

    // Request is taken only while idle; a busy device ignores it
    assign take_req = link.req && (state_reg == ST_IDLE);

    // Last dummy clock; the guard also ends a count that starts at zero
    assign last_dummy = (dummy_reg <= DUMMY_W'(1));

    // Wrapped read only valid with zero mode bits
    always_comb begin
        accept_now = opcode_known(op_reg);
        if (op_reg == OP_WRAP_READ_144 && mode_reg != WRAP_MODE_BITS) begin
            accept_now = 1'b0; // RULE8
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------

    // Sequencer state: idle, dummy wait, reply
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            // Back to idle, nothing pending
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // A request starts either the dummy wait or the reply
                    if (link.req) begin
                        // Wrapped read waits for its dummy clocks
                        if (link.opcode == OP_WRAP_READ_144) begin
                            state_reg <= ST_DUMMY; // RULE7
                        end else begin
                            state_reg <= ST_REPLY;
                        end
                    end
                end
                ST_DUMMY: begin
                    // Leave on the last dummy clock
                    if (last_dummy) begin
                        state_reg <= ST_REPLY; // RULE7
                    end
                end
                ST_REPLY: begin
                    // One reply cycle, then ready again
                    state_reg <= ST_IDLE;
                end
                default: begin
                    // Stray code falls back to idle
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Dummy clock counter, loaded when a wrapped read is taken
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            dummy_reg <= '0;
        end else if (take_req && link.opcode == OP_WRAP_READ_144) begin
            dummy_reg <= WRAP_DUMMY_CLOCKS; // RULE7
        end else if (state_reg == ST_DUMMY) begin
            dummy_reg <= dummy_reg - DUMMY_W'(1);
        end
    end

    // Request latch; opcode and address stand until the next request
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            // Nothing latched after reset
            op_reg <= OP_NOP;
            addr_reg <= '0;
            mode_reg <= '0;
        end else if (take_req) begin
            op_reg <= link.opcode;
            addr_reg <= link.addr;
            mode_reg <= link.mode_bits;
        end
    end

    // ----------------------------------------------------------------
    // Answer
    // ----------------------------------------------------------------

    // Answer strobe, byte and accepted flag
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            ack_reg <= 1'b0;
            data_reg <= NO_DATA;
            acc_reg <= 1'b0;
        end else begin
            ack_reg <= (state_reg == ST_REPLY);
            // Reply cycle: latch answer byte and accepted flag
            if (state_reg == ST_REPLY) begin
                acc_reg <= accept_now;
                // Only the table read returns content
                if (op_reg == OP_PARAM_READ) begin
                    data_reg <= table_byte(addr_reg); // RULE10
                end else begin
                    // Other commands answer with filler
                    data_reg <= NO_DATA;
                end
            end
        end
    end

    // Command forwarded to execution logic
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            cmd_valid_reg <= 1'b0;
        end else begin
            // Refused commands are not forwarded
            cmd_valid_reg <= (state_reg == ST_REPLY) && accept_now; // RULE3 RULE5
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------

    // All outputs come straight from registers
    assign link.ack = ack_reg;
    assign link.data = data_reg;
    assign link.accepted = acc_reg;
    assign o_cmd_valid = cmd_valid_reg;
    assign o_cmd_opcode = op_reg;
    assign o_cmd_addr = addr_reg;

endmodule

//--- rtl/param_table_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host end: issues one request, waits for the answer
// ----------------------------------------------------------------
module param_table_host
    import param_table_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Link to device
    param_link_if.host link,
    // User request
    input wire logic i_start,
    input wire req_kind_t i_kind,
    input wire logic [ADDR_W-1:0] i_addr,
    // User answer
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_data,
    output logic o_accepted
);

    // Opcode for each request kind
    function automatic logic [OPCODE_W-1:0] kind_opcode(input req_kind_t k);
        case (k)
            KIND_PARAM_READ: kind_opcode = OP_PARAM_READ;
            KIND_PAGE_PROGRAM: kind_opcode = OP_PAGE_PROGRAM; // RULE5
            KIND_QUAD_PAGE_PROGRAM: kind_opcode = OP_QUAD_PAGE_PROGRAM; // RULE5
            KIND_READ_PROTECT: kind_opcode = OP_READ_PROTECT; // RULE3
            KIND_WRITE_PROTECT: kind_opcode = OP_WRITE_PROTECT; // RULE3
            KIND_LOCK_PROTECT: kind_opcode = OP_LOCK_PROTECT; // RULE3
            KIND_NV_LOCK_DOWN: kind_opcode = OP_NV_LOCK_DOWN; // RULE3
            KIND_GLOBAL_UNLOCK: kind_opcode = OP_GLOBAL_UNLOCK; // RULE3
            KIND_READ_SEC_ID: kind_opcode = OP_READ_SEC_ID; // RULE4
            KIND_PROGRAM_SEC_ID: kind_opcode = OP_PROGRAM_SEC_ID; // RULE4
            KIND_LOCKOUT_SEC_ID: kind_opcode = OP_LOCKOUT_SEC_ID; // RULE4
            KIND_WRAP_READ: kind_opcode = OP_WRAP_READ_144; // RULE9
            default: kind_opcode = OP_NOP;
        endcase
    endfunction

    typedef enum logic [1:0] {
        HS_IDLE = 2'b01,
        HS_WAIT = 2'b10
    } host_state_t;

    host_state_t state_reg; // Host state
    logic req_reg; // Request strobe
    logic [OPCODE_W-1:0] op_reg; // Opcode driven
    logic [ADDR_W-1:0] addr_reg; // Address driven
    logic done_reg; // Done strobe
    logic [7:0] data_reg; // Captured byte
    logic acc_reg; // Captured accepted flag

    // ----------------------------------------------------------------
    // Request and wait
    // ----------------------------------------------------------------

    // Issue on start, release on answer
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            state_reg <= HS_IDLE;
            req_reg <= 1'b0;
            op_reg <= OP_NOP;
            addr_reg <= '0;
        end else begin
            req_reg <= 1'b0;
            case (state_reg)
                HS_IDLE: begin
                    if (i_start) begin
                        req_reg <= 1'b1;
                        op_reg <= kind_opcode(i_kind);
                        addr_reg <= i_addr;
                        state_reg <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    if (link.ack) begin
                        state_reg <= HS_IDLE;
                    end
                end
                default: begin
                    state_reg <= HS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Answer capture
    // ----------------------------------------------------------------

    // Latch answer, pulse done
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            done_reg <= 1'b0;
            data_reg <= NO_DATA;
            acc_reg <= 1'b0;
        end else begin
            done_reg <= (state_reg == HS_WAIT) && link.ack;
            if (state_reg == HS_WAIT && link.ack) begin
                data_reg <= link.data;
                acc_reg <= link.accepted;
            end
        end
    end

    assign link.req = req_reg;
    assign link.opcode = op_reg;
    assign link.addr = addr_reg;
    assign link.mode_bits = WRAP_MODE_BITS; // RULE8
    assign o_busy = (state_reg == HS_WAIT);
    assign o_done = done_reg;
    assign o_data = data_reg;
    assign o_accepted = acc_reg;

endmodule

//--- test/sfdp_instruction_table_asserts.sv
`timescale 1ns/1ps
module sfdp_instruction_table_asserts
    import param_table_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // Link signals
    input wire logic req,
    input wire logic [OPCODE_W-1:0] opcode,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [MODE_W-1:0] mode_bits,
    input wire logic ack,
    input wire logic [7:0] data,
    input wire logic accepted
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    // --------------------------------
    // Open request capture
    // --------------------------------
    logic [OPCODE_W-1:0] op_reg; // Opcode in flight
    logic [ADDR_W-1:0] addr_reg; // Address in flight
    logic tbl_ack; // Answer to a table read
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            op_reg <= 8'h00;
            addr_reg <= 24'h000000;
        end else if (req) begin
            op_reg <= opcode;
            addr_reg <= addr;
        end
    end
    assign tbl_ack = ack && (op_reg == OP_PARAM_READ);
    // --------------------------------
    // Reply timing
    // --------------------------------
    sequence s_short_reply;
        !ack ##1 ack;
    endsequence
    sequence s_wrap_reply;
        !ack [*7] ##1 ack;
    endsequence
    a_reply_latency: assert property (req && opcode != 8'hEC |=> s_short_reply)
        else $error("short reply not two cycles after request");
    a_wrap_dummy: assert property (req && opcode == 8'hEC && mode_bits == 3'h0 |=> s_wrap_reply)
        else $error("wrapped read reply not after six dummy clocks");
    // --------------------------------
    // Table content and acceptance
    // --------------------------------
    a_reserved_fill: assert property (tbl_ack && addr_reg inside {[24'h00021B:24'h00021F]} |-> data == 8'hFF)
        else $error("reserved byte not all ones");
    a_exit_time: assert property (tbl_ack && addr_reg == 24'h00021A |-> data == 8'hFF)
        else $error("exit time byte not reserved value");
    a_protect_ops: assert property (ack && op_reg inside {8'h72, 8'h42, 8'h8D, 8'hE8, 8'h98} |-> accepted)
        else $error("protection opcode refused");
    a_sec_id_ops: assert property (ack && op_reg inside {8'h88, 8'hA5, 8'h85} |-> accepted)
        else $error("security id opcode refused");
    a_program_ops: assert property (ack && op_reg inside {8'h02, 8'h32} |-> accepted)
        else $error("program opcode refused");
    a_power_down: assert property (tbl_ack && addr_reg inside {24'h00023A, 24'h00023B} |-> data == 8'hFF)
        else $error("power-down opcode byte not reserved");
    a_wrap_fields: assert property (tbl_ack && addr_reg == 24'h00023C |-> data == 8'h06)
        else $error("wrapped read dummy or mode field wrong");
    a_wrap_opcode: assert property (tbl_ack && addr_reg == 24'h00023D |-> data == 8'hEC)
        else $error("wrapped read opcode byte wrong");
    a_basic_ops: assert property (tbl_ack && addr_reg == 24'h000222 |-> data == 8'h99)
        else $error("reset memory opcode byte wrong");
    a_answer_hold: assert property (!ack |-> $stable(data) && $stable(accepted))
        else $error("answer changed without acknowledge");
endmodule

//--- test/sfdp_instruction_table_tb_top.sv
`timescale 1ns/1ps
module sfdp_instruction_table_tb_top;
    import param_table_pkg::*;
    // --------------------------------
    // Signals and notes
    // --------------------------------
    typedef struct {
        logic [7:0] op;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        logic acc;
        int lat;
        int cyc;
    } note_t;
    logic i_clock = 1'b0; // 250 MHz clock
    logic i_resetn = 1'b0; // Reset, active low
    logic i_start = 1'b0; // User start
    req_kind_t i_kind = KIND_PARAM_READ; // Request kind
    logic [ADDR_W-1:0] i_addr = 24'h000000; // Request address
    logic o_busy;
    logic o_done;
    logic [7:0] o_data;
    logic o_accepted;
    logic cmd_valid; // Forwarded command pulse
    logic [7:0] cmd_opcode; // Forwarded opcode
    logic [ADDR_W-1:0] cmd_addr; // Forwarded address
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    int seed = 51;
    int n_req = 0;
    int n_cmd = 0;
    note_t notes[$]; // Expected results, oldest first
    note_t nt;
    // Expected window bytes from 21AH up
    logic [7:0] exp_rom [0:35] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h66, 8'h99, 8'h38,
        8'hFF, 8'h05, 8'h01, 8'h35, 8'h06, 8'h04, 8'h02, 8'h32, 8'hB0, 8'h30, 8'h72, 8'h42, 8'h8D, 8'hE8,
        8'h98, 8'h88, 8'hA5, 8'h85, 8'hC0, 8'h9F, 8'hAF, 8'h5A, 8'hFF, 8'hFF, 8'h06, 8'hEC};
    // Opcode on the link for each kind
    logic [7:0] kind_op [0:11] = '{8'h5A, 8'h02, 8'h32, 8'h72, 8'h42, 8'h8D, 8'hE8, 8'h98, 8'h88, 8'hA5,
        8'h85, 8'hEC};
    param_link_if link();
    param_table_device u_param_table_device (.i_clock(i_clock), .i_resetn(i_resetn), .link(link),
        .o_cmd_valid(cmd_valid), .o_cmd_opcode(cmd_opcode), .o_cmd_addr(cmd_addr));
    param_table_host u_param_table_host (.i_clock(i_clock), .i_resetn(i_resetn), .link(link),
        .i_start(i_start), .i_kind(i_kind), .i_addr(i_addr), .o_busy(o_busy), .o_done(o_done),
        .o_data(o_data), .o_accepted(o_accepted));
    sfdp_instruction_table_asserts u_sfdp_instruction_table_asserts (.i_clock(i_clock),
        .i_resetn(i_resetn), .req(link.req), .opcode(link.opcode), .addr(link.addr),
        .mode_bits(link.mode_bits), .ack(link.ack), .data(link.data), .accepted(link.accepted));
    // Clock, cycle count, forwarded commands
    always #2 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cmd_valid === 1'b1) n_cmd++;
    end
    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    function automatic logic [7:0] exp_byte(input logic [ADDR_W-1:0] a);
        if (a >= 24'h00021A && a <= 24'h00023D) return exp_rom[a - 24'h00021A];
        return 8'hFF;
    endfunction
    // Issue one request; a held start while busy must be refused
    task automatic do_req(input req_kind_t k, input logic [ADDR_W-1:0] a);
        note_t n;
        @(posedge i_clock) #1;
        while (o_busy !== 1'b0) begin
            i_addr = 24'($random(seed));
            @(posedge i_clock) #1;
        end
        n.op = kind_op[k];
        n.addr = a;
        n.data = (k == KIND_PARAM_READ) ? exp_byte(a) : 8'hFF;
        n.acc = 1'b1;
        n.lat = (k == KIND_WRAP_READ) ? 10 : 4;
        n.cyc = cyc;
        notes.push_back(n);
        n_req++;
        i_start = 1'b1;
        i_kind = k;
        i_addr = a;
    endtask
    task automatic drain();
        @(posedge i_clock) #1;
        i_start = 1'b0;
        repeat (12) @(posedge i_clock);
    endtask
    task automatic apply_reset();
        @(posedge i_clock) #1;
        i_resetn = 1'b0;
        repeat (2) @(posedge i_clock);
        #1 i_resetn = 1'b1;
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // --------------------------------
    // Result monitor
    // --------------------------------
    always @(posedge i_clock) begin
        #1;
        if (link.req === 1'b1 && notes.size() > 0) begin
            check(link.opcode, notes[0].op, "opcode");
            check(o_busy, 1'b1, "busy while requesting");
            check(link.mode_bits, 3'h0, "mode bits");
            if (notes[0].op == 8'h5A) check(link.addr, notes[0].addr, "address");
        end
        if (cmd_valid === 1'b1 && notes.size() > 0) begin
            check(cmd_opcode, notes[0].op, "forwarded opcode");
            check(cmd_addr, notes[0].addr, "forwarded address");
        end
        if (o_done === 1'b1) begin
            check(o_busy, 1'b0, "busy after done");
            if (notes.size() == 0) begin
                check(1'b1, 1'b0, "done without request");
            end else begin
                nt = notes.pop_front();
                check(o_data, nt.data, "data");
                check(o_accepted, nt.acc, "accepted");
                check(cyc - nt.cyc, nt.lat, "latency");
            end
        end
    end
    // --------------------------------
    // Main sequence and watchdog
    // --------------------------------
    initial begin
        apply_reset();
        for (int p = 0; p < 2; p++) begin
            for (int a = 'h219; a <= 'h23E; a++) do_req(KIND_PARAM_READ, 24'(a));
            for (int k = 0; k < 12; k++) do_req(req_kind_t'(k), 24'($random(seed)));
        end
        for (int i = 0; i < 30; i++) do_req(KIND_PARAM_READ, 24'h000212 + 24'($random(seed) & 63));
        drain();
        apply_reset();
        do_req(KIND_PARAM_READ, 24'h00023C);
        do_req(KIND_WRAP_READ, 24'h000000);
        do_req(KIND_PARAM_READ, 24'h00021A);
        drain();
        check(notes.size(), 0, "outstanding requests");
        check(n_cmd, n_req, "forwarded commands");
        stop_test();
    end
    initial begin
        #20000;
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
